/* design/console_manual_control_sequencer.sv */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module console_manual_control_sequencer #(
  parameter int MAIN_BYTES = 8192,
  parameter int IO_UNITS   = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            mode_switch,
  input  wire logic                  start_key,
  input  wire logic                  stop_key,
  input  wire logic                  time_sharing_off,
  input  wire logic                  aux_storage_switch,
  input  wire logic [3:0]            addr_switch1,
  input  wire logic [3:0]            addr_switch2,
  input  wire logic [3:0]            addr_switch3,
  input  wire logic [3:0]            addr_switch4,
  input  wire logic                  io_request,
  input  wire logic [IO_UNITS-1:0]   io_execute,
  input  wire logic                  ifetch_begin,
  input  wire logic                  io_instr_done,
  input  wire logic                  addr_step,
  input  wire logic [15:0]           cpu_next_addr,
  input  wire logic [9:0]            mem_rdata,
  output logic                       mem_rd,
  output logic                       mem_wr,
  output logic                       mem_aux,
  output logic [14:0]                mem_addr,
  output logic [9:0]                 mem_wdata,
  output logic                       run_flag,
  output logic                       store_parity_error_flag,
  output logic                       stop_request,
  output logic                       fetch_start,
  output logic                       service_start,
  output logic [3:0]                 high_digit_reg,
  output logic [3:0]                 second_digit_reg,
  output logic [3:0]                 third_digit_reg,
  output logic [3:0]                 fourth_digit_reg,
  output logic [3:0]                 storage_extension_reg,
  output logic [4:0]                 upper_nibble_reg,
  output logic [4:0]                 lower_nibble_reg,
  output logic [4:0]                 aux_pointer_reg,
  output logic [4:0]                 indicator_nibble_reg
);
  // ---------------------------------
  // Elaboration checks
  // ---------------------------------
  if (MAIN_BYTES < 256 || MAIN_BYTES > 32768 || (MAIN_BYTES & (MAIN_BYTES - 1)) != 0)
    $error("MAIN_BYTES must be a power of two from 256 to 32768");
  if (IO_UNITS < 1 || IO_UNITS > 16)
    $error("IO_UNITS must be 1 to 16");

  localparam logic [14:0] MAIN_TOP = 15'(MAIN_BYTES - 1);

  typedef enum logic [28:0] {
    S_IDLE      = 29'h0000001, S_START    = 29'h0000002,
    S_SW1       = 29'h0000004, S_SW2      = 29'h0000008,
    S_MOVE_S    = 29'h0000010, S_MOVE_E   = 29'h0000020,
    S_LOAD_TR   = 29'h0000040, S_CLEAR_PI = 29'h0000080,
    S_SENSE     = 29'h0000100, S_DISPATCH = 29'h0000200,
    S_PSW_A     = 29'h0000400, S_PSW_B    = 29'h0000800,
    S_PSW_C     = 29'h0001000, S_PSW_D    = 29'h0002000,
    S_RUN       = 29'h0004000, S_SAVE_HI  = 29'h0008000,
    S_SAVE_LO   = 29'h0010000, S_STOP_CHK = 29'h0020000,
    S_HOLD      = 29'h0040000, S_DISP_RD  = 29'h0080000,
    S_DISP_WAIT = 29'h0100000, S_DISP_CAP = 29'h0200000,
    S_DISP_WB   = 29'h0400000, S_SCAN_RD  = 29'h0800000,
    S_SCAN_WAIT = 29'h1000000, S_SCAN_CAP = 29'h2000000,
    S_SCAN_WB   = 29'h4000000, S_SCAN_INC = 29'h8000000,
    S_HALT      = 29'h10000000
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ---------------------------------
  // Helpers
  // ---------------------------------
  function automatic logic [4:0] sense_nib(input logic [3:0] v);
    sense_nib = {~^v, v};
  endfunction : sense_nib

  function automatic logic [9:0] pack_byte(input logic [3:0] hi, input logic [3:0] lo);
    pack_byte = {sense_nib(hi), sense_nib(lo)};
  endfunction : pack_byte

  function automatic logic nib_ok(input logic [4:0] n);
    nib_ok = ^n;
  endfunction : nib_ok

  logic [14:0] cur_addr;
  logic [14:0] inc_addr;
  logic        main_wrap;
  logic        aux_wrap;
  logic        byte_bad;

  assign cur_addr  = {storage_extension_reg[2:0], second_digit_reg,
                      third_digit_reg, fourth_digit_reg};
  assign main_wrap = cur_addr == MAIN_TOP;
  assign inc_addr  = main_wrap ? 15'h0000 : 15'(cur_addr + 15'h0001);
  assign aux_wrap  = {third_digit_reg, fourth_digit_reg} == console_seq_pkg::AUX_LAST;
  assign byte_bad  = !nib_ok(upper_nibble_reg) || !nib_ok(lower_nibble_reg);

  // ---------------------------------
  // Sequencer
  // ---------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:      if (start_key) state_next = S_START;
      S_START:     if (io_request) state_next = S_IDLE;
                   else if (aux_storage_switch) state_next = S_LOAD_TR;
                   else state_next = S_SW1;
      S_SW1:       state_next = S_SW2;
      S_SW2:       state_next = S_MOVE_S;
      S_MOVE_S:    state_next = S_MOVE_E;
      S_MOVE_E:    state_next = S_LOAD_TR;
      S_LOAD_TR:   state_next = S_CLEAR_PI;
      S_CLEAR_PI:  state_next = S_SENSE;
      S_SENSE:     state_next = S_DISPATCH;
      S_DISPATCH: begin
        case (lower_nibble_reg[3:0])
          console_seq_pkg::MODE_PROCESS:
            state_next = aux_storage_switch ? S_HALT : S_PSW_A;
          console_seq_pkg::MODE_DISPLAY: state_next = S_DISP_RD;
          console_seq_pkg::MODE_SCAN:    state_next = S_SCAN_RD;
          default:                       state_next = S_HALT;
        endcase
      end
      S_PSW_A:     state_next = S_PSW_B;
      S_PSW_B:     state_next = S_PSW_C;
      S_PSW_C:     state_next = S_PSW_D;
      S_PSW_D:     state_next = S_RUN;
      S_RUN: begin
        if (ifetch_begin && stop_request) state_next = S_SAVE_HI;
        else if (io_instr_done && time_sharing_off) state_next = S_SAVE_HI;
        else if (addr_step && main_wrap) state_next = S_HALT;
      end
      S_SAVE_HI:   state_next = S_SAVE_LO;
      S_SAVE_LO:   state_next = S_STOP_CHK;
      S_STOP_CHK:  state_next = stop_request ? S_DISP_RD : S_HOLD;
      S_HOLD:      if (io_execute == '0) state_next = S_RUN;
      S_DISP_RD:   state_next = S_DISP_WAIT;
      S_DISP_WAIT: state_next = S_DISP_CAP;
      S_DISP_CAP:  state_next = S_DISP_WB;
      S_DISP_WB:   state_next = S_HALT;
      S_SCAN_RD:   state_next = S_SCAN_WAIT;
      S_SCAN_WAIT: state_next = S_SCAN_CAP;
      S_SCAN_CAP:  state_next = S_SCAN_WB;
      S_SCAN_WB:   state_next = byte_bad ? S_HALT : S_SCAN_INC;
      S_SCAN_INC:  state_next = stop_request ? S_DISP_RD : S_SCAN_RD;
      S_HALT:      state_next = S_IDLE;
      default:     state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------
  // Stop request latch and run flag
  // ---------------------------------
  // The key press wins over the clear made by the halt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_request <= 1'b0;
    end else if (stop_key) begin
      stop_request <= 1'b1;
    end else if (state_reg == S_HALT || (state_reg == S_IDLE && start_key)) begin
      stop_request <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_flag <= 1'b0;
    end else if (state_reg == S_HALT) begin
      run_flag <= 1'b0;
    end else if (state_reg == S_IDLE && start_key) begin
      run_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_parity_error_flag <= 1'b0;
    end else if (state_reg == S_SCAN_WB && byte_bad) begin
      store_parity_error_flag <= 1'b1;
    end else if (state_reg == S_IDLE && start_key) begin
      store_parity_error_flag <= 1'b0;
    end
  end

  // ---------------------------------
  // Phase pulses
  // ---------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_start   <= 1'b0;
      service_start <= 1'b0;
    end else begin
      fetch_start   <= (state_reg == S_PSW_D) ||
                       (state_reg == S_HOLD && io_execute == '0);
      service_start <= state_reg == S_START && io_request;
    end
  end

  // ---------------------------------
  // Address digits
  // ---------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_digit_reg        <= console_seq_pkg::DIGIT_ZERO;
      second_digit_reg      <= console_seq_pkg::DIGIT_ZERO;
      third_digit_reg       <= console_seq_pkg::DIGIT_ZERO;
      fourth_digit_reg      <= console_seq_pkg::DIGIT_ZERO;
      storage_extension_reg <= console_seq_pkg::DIGIT_ZERO;
    end else begin
      case (state_reg)
        S_START: if (!io_request && aux_storage_switch) begin
          high_digit_reg        <= console_seq_pkg::DIGIT_ZERO;
          second_digit_reg      <= console_seq_pkg::DIGIT_ZERO;
          storage_extension_reg <= console_seq_pkg::DIGIT_ZERO;
        end
        S_MOVE_S: begin
          second_digit_reg      <= lower_nibble_reg[3:0];
          storage_extension_reg <= upper_nibble_reg[3:0];
        end
        S_MOVE_E: high_digit_reg <= upper_nibble_reg[3:0];
        S_LOAD_TR: begin
          third_digit_reg  <= addr_switch3;
          fourth_digit_reg <= addr_switch4;
        end
        S_PSW_C: begin
          high_digit_reg        <= mem_rdata[8:5];
          storage_extension_reg <= {1'b0, mem_rdata[7:5]};
          second_digit_reg      <= mem_rdata[3:0];
        end
        S_PSW_D: begin
          third_digit_reg  <= mem_rdata[8:5];
          fourth_digit_reg <= mem_rdata[3:0];
        end
        S_RUN: begin
          if ((ifetch_begin && stop_request) || (io_instr_done && time_sharing_off)) begin
            high_digit_reg        <= cpu_next_addr[15:12];
            storage_extension_reg <= {1'b0, cpu_next_addr[14:12]};
            second_digit_reg      <= cpu_next_addr[11:8];
            third_digit_reg       <= cpu_next_addr[7:4];
            fourth_digit_reg      <= cpu_next_addr[3:0];
          end else if (addr_step && !main_wrap) begin
            {storage_extension_reg[2:0], second_digit_reg,
             third_digit_reg, fourth_digit_reg} <= inc_addr;
          end
        end
        S_SCAN_INC: begin
          if (aux_storage_switch) begin
            second_digit_reg <= console_seq_pkg::DIGIT_ZERO;
            {third_digit_reg, fourth_digit_reg} <=
              8'({third_digit_reg, fourth_digit_reg} + 8'h01);
          end else begin
            {storage_extension_reg[2:0], second_digit_reg,
             third_digit_reg, fourth_digit_reg} <= inc_addr;
            if (main_wrap) begin
              high_digit_reg <= console_seq_pkg::DIGIT_ZERO;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------
  // Data nibbles, pointer, indicator
  // ---------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_nibble_reg <= console_seq_pkg::NIB_RESET;
      lower_nibble_reg <= console_seq_pkg::NIB_RESET;
    end else begin
      case (state_reg)
        S_SW1:      lower_nibble_reg <= sense_nib(addr_switch1);
        S_SW2: begin
          upper_nibble_reg <= lower_nibble_reg;
          lower_nibble_reg <= sense_nib(addr_switch2);
        end
        S_SENSE:    lower_nibble_reg <= sense_nib(mode_switch);
        S_DISP_CAP, S_SCAN_CAP: begin
          upper_nibble_reg <= mem_rdata[9:5];
          lower_nibble_reg <= mem_rdata[4:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_pointer_reg      <= console_seq_pkg::PARITY_ONLY;
      indicator_nibble_reg <= console_seq_pkg::PARITY_ONLY;
    end else if (state_reg == S_CLEAR_PI || state_reg == S_STOP_CHK) begin
      aux_pointer_reg      <= console_seq_pkg::PARITY_ONLY;
      indicator_nibble_reg <= console_seq_pkg::PARITY_ONLY;
    end else if (state_reg == S_RUN && addr_step && main_wrap) begin
      indicator_nibble_reg <= sense_nib(console_seq_pkg::ADDR_ERR);
    end
  end

  // ---------------------------------
  // Storage port
  // ---------------------------------
  // Read data arrive in the cycle after the strobe is on the pins,
  // so display and scan reads spend one wait state before capture; the two PSW reads overlap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_aux   <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (state_reg)
        S_PSW_A, S_PSW_B: begin
          mem_rd   <= 1'b1;
          mem_aux  <= 1'b1;
          mem_addr <= {7'h00, (state_reg == S_PSW_A) ? console_seq_pkg::AUX_NIA_HI
                                                     : console_seq_pkg::AUX_NIA_LO};
        end
        S_SAVE_HI, S_SAVE_LO: begin
          mem_wr    <= 1'b1;
          mem_aux   <= 1'b1;
          mem_addr  <= {7'h00, (state_reg == S_SAVE_HI) ? console_seq_pkg::AUX_NIA_HI
                                                        : console_seq_pkg::AUX_NIA_LO};
          mem_wdata <= (state_reg == S_SAVE_HI)
                       ? pack_byte(high_digit_reg, second_digit_reg)
                       : pack_byte(third_digit_reg, fourth_digit_reg);
        end
        S_DISP_RD, S_SCAN_RD: begin
          mem_rd   <= 1'b1;
          mem_aux  <= aux_storage_switch;
          mem_addr <= cur_addr;
        end
        S_DISP_WB, S_SCAN_WB: begin
          mem_wr    <= 1'b1;
          mem_aux   <= aux_storage_switch;
          mem_addr  <= cur_addr;
          mem_wdata <= {upper_nibble_reg, lower_nibble_reg};
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------
  // Checks
  // ---------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence scan_bad_wb;
    state_reg == S_SCAN_WB && byte_bad;
  endsequence

  chk_scan_parity_stop: assert property (scan_bad_wb |=> ##1 !run_flag && store_parity_error_flag)
    else $error("Bad parity did not stop the scan");
  chk_error_display: assert property (scan_bad_wb |=> $stable(cur_addr) && $stable(lower_nibble_reg))
    else $error("Failing address or byte lost");
  chk_hold_loop: assert property (state_reg == S_HOLD && io_execute != '0 |=> state_reg == S_HOLD)
    else $error("Holding loop left with execute latch set");
  chk_aux_zero: assert property (state_reg == S_START && aux_storage_switch && !io_request |=> high_digit_reg == 4'h0 && second_digit_reg == 4'h0)
    else $error("High digits not cleared");
  chk_clear_pi: assert property (state_reg == S_CLEAR_PI |=> aux_pointer_reg == 5'h10 && indicator_nibble_reg == 5'h10)
    else $error("Pointer or indicator not cleared");
  chk_display_seq: assert property (state_reg == S_DISP_RD |=> mem_rd ##3 mem_wr ##1 !run_flag)
    else $error("Display sequence wrong");
  chk_addr_step: assert property (state_reg == S_SCAN_INC && !aux_storage_switch && !main_wrap |=> cur_addr == $past(cur_addr) + 15'h0001)
    else $error("Scan address did not step");
  chk_main_wrap: assert property (state_reg == S_SCAN_INC && !aux_storage_switch && main_wrap |=> cur_addr == 15'h0000 && high_digit_reg == 4'h0)
    else $error("Scan wrap wrong");
  chk_aux_wrap: assert property (state_reg == S_SCAN_INC && aux_storage_switch && aux_wrap |=> {third_digit_reg, fourth_digit_reg} == 8'h00)
    else $error("Aux wrap wrong");
  chk_wrap_error: assert property (state_reg == S_RUN && addr_step && main_wrap |=> indicator_nibble_reg[3:0] == 4'h5 ##1 !run_flag)
    else $error("Address error not flagged");
  chk_service_first: assert property (state_reg == S_START && io_request |=> service_start && state_reg == S_IDLE)
    else $error("I/O request not served first");
  chk_stop_latch: assert property (stop_key |=> stop_request)
    else $error("Stop key not latched");
endmodule : console_manual_control_sequencer

/* design/console_seq_pkg.sv */
package console_seq_pkg;
  // ---------------------------------
  // Mode switch codes
  // ---------------------------------
  localparam logic [3:0] MODE_PROCESS = 4'h8;
  localparam logic [3:0] MODE_DISPLAY = 4'h4;
  localparam logic [3:0] MODE_SCAN    = 4'h2;
  // ---------------------------------
  // Widths and aux storage layout
  // ---------------------------------
  localparam int         ADDR_W       = 15;
  localparam int         WORD_W       = 10;
  localparam logic [7:0] AUX_NIA_HI   = 8'h30;
  localparam logic [7:0] AUX_NIA_LO   = 8'h31;
  localparam logic [7:0] AUX_LAST     = 8'hFF;
  // ---------------------------------
  // Reset, clear and error values
  // ---------------------------------
  localparam logic [4:0] PARITY_ONLY  = 5'h10;
  localparam logic [3:0] ADDR_ERR     = 4'h5;
  localparam logic [3:0] DIGIT_ZERO   = 4'h0;
  localparam logic [4:0] NIB_RESET    = 5'h10;
endpackage : console_seq_pkg

/* verification/console_mem_model.sv */
`timescale 1ns/1ps
// ---------------------------------
// Storage model, main and aux alike
// ---------------------------------
module console_mem_model #(
  parameter logic [7:0] BAD_LO = 8'h01
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mem_rd,
  input  wire logic [14:0] mem_addr,
  output logic [9:0]       mem_rdata
);
  function automatic logic [9:0] byte_at(input logic [14:0] a);
    byte_at = {~^a[7:4], a[7:4], ~^a[3:0], a[3:0]};
    if (a[7:0] == BAD_LO) byte_at[9] = ~byte_at[9];
  endfunction : byte_at
  // Data stand only in the cycle after the strobe; a toggling bus catches late sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mem_rdata <= 10'h155;
    else if (mem_rd) mem_rdata <= byte_at(mem_addr);
    else mem_rdata <= ~mem_rdata;
  end
endmodule : console_mem_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, start_key, stop_key, aux_sw, io_request, ifetch_begin, tso, io_done;
  logic [3:0]  mode_switch, sw1, sw2, sw3, sw4, d_hi, d_s, d_t, d_r, d_ext, io_exec;
  logic [15:0] cpu_next_addr;
  logic [9:0]  mem_rdata, mem_wdata, last_wr_data;
  logic        mem_rd, mem_wr, mem_aux, run_flag, perr, stop_request, fetch_start;
  logic        service_start, saw_nia, prev_ok, last_aux, step;
  logic [14:0] mem_addr, last_wr_addr, diff;
  logic [4:0]  nib_u, nib_l, ptr, ind;
  int          n_mismatch, total_checks, cycles, n_fetch, n_service, n_order, i;
  console_manual_control_sequencer uut (.clk(clk), .rst_n(rst_n), .mode_switch(mode_switch),
    .start_key(start_key), .stop_key(stop_key), .time_sharing_off(tso),
    .aux_storage_switch(aux_sw), .addr_switch1(sw1), .addr_switch2(sw2), .addr_switch3(sw3),
    .addr_switch4(sw4), .io_request(io_request), .io_execute(io_exec), .ifetch_begin(ifetch_begin),
    .io_instr_done(io_done), .addr_step(step), .cpu_next_addr(cpu_next_addr),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_aux(mem_aux),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .run_flag(run_flag),
    .store_parity_error_flag(perr), .stop_request(stop_request), .fetch_start(fetch_start),
    .service_start(service_start), .high_digit_reg(d_hi), .second_digit_reg(d_s),
    .third_digit_reg(d_t), .fourth_digit_reg(d_r), .storage_extension_reg(d_ext),
    .upper_nibble_reg(nib_u), .lower_nibble_reg(nib_l), .aux_pointer_reg(ptr),
    .indicator_nibble_reg(ind));
  console_mem_model mem (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  // ---------------------------------
  // Bus watcher and hang guard
  // ---------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      give_verdict();
    end
    if (fetch_start === 1'b1) n_fetch++;
    if (service_start === 1'b1) n_service++;
    if (mem_wr === 1'b1) begin
      diff = mem_addr - last_wr_addr;
      if (mode_switch == console_seq_pkg::MODE_SCAN && prev_ok &&
          (mem_aux ? diff[7:0] != 8'h01 : diff[12:0] != 13'h0001)) n_order++;
      if (mem_aux === 1'b1 && mem_addr === 15'h0030) saw_nia = 1'b1;
      last_wr_addr = mem_addr;
      last_wr_data = mem_wdata;
      last_aux = mem_aux;
      prev_ok = 1'b1;
    end
  end
  function automatic logic [9:0] exp_byte(input logic [7:0] a);
    exp_byte = {~^a[7:4], a[7:4], ~^a[3:0], a[3:0]};
    if (a == 8'h01) exp_byte[9] = ~exp_byte[9];
  endfunction : exp_byte
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic run_op(input logic [3:0] m, input logic ax, input logic [15:0] sw);
    @(posedge clk);
    mode_switch <= m;
    aux_sw <= ax;
    {sw1, sw2, sw3, sw4} <= sw;
    prev_ok = 1'b0;
    @(posedge clk);
    start_key <= 1'b1;
    @(posedge clk);
    start_key <= 1'b0;
  endtask : run_op
  task automatic wait_halt();
    repeat (4) @(posedge clk);
    for (i = 0; i < 3000 && run_flag !== 1'b0; i++) @(posedge clk);
    check(run_flag, 16'h0000);
  endtask : wait_halt
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, start_key, stop_key, aux_sw, io_request, ifetch_begin, tso, io_done, step} = 9'h000;
    {mode_switch, sw1, sw2, sw3, sw4, io_exec, cpu_next_addr} = 40'h0;
    {n_mismatch, total_checks, cycles, n_fetch, n_service, n_order} = 192'h0;
    {saw_nia, prev_ok, last_aux, last_wr_addr, last_wr_data} = 28'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({ptr, ind}, 16'h0210);
    io_request <= 1'b1;
    run_op(console_seq_pkg::MODE_DISPLAY, 1'b0, 16'h1123);
    repeat (6) @(posedge clk);
    check(n_service, 16'h0001);
    io_request <= 1'b0;
    run_op(console_seq_pkg::MODE_DISPLAY, 1'b0, 16'h1123);
    wait_halt();
    check({d_hi, d_s, d_t, d_r}, 16'h1123);
    check(d_ext, 16'h0001);
    check({nib_u, nib_l}, exp_byte(8'h23));
    check({last_wr_addr, last_wr_data}, {15'h1123, exp_byte(8'h23)});
    check({ptr, ind}, 16'h0210);
    // Operator keeps aux storage off while running the program
    run_op(console_seq_pkg::MODE_PROCESS, 1'b0, 16'h0000);
    for (i = 0; i < 200 && n_fetch == 0; i++) @(posedge clk);
    check(n_fetch, 16'h0001);
    check(run_flag, 16'h0001);
    stop_key <= 1'b1;
    @(posedge clk);
    {stop_key, ifetch_begin, cpu_next_addr} <= {2'b01, 16'h0456};
    @(posedge clk);
    ifetch_begin <= 1'b0;
    wait_halt();
    check(saw_nia, 16'h0001);
    check({d_hi, d_s, d_t, d_r}, 16'h0456);
    check({nib_u, nib_l}, exp_byte(8'h56));
    // Time sharing off: save the address, hold while a unit executes, then step off the top into an address error
    run_op(console_seq_pkg::MODE_PROCESS, 1'b0, 16'h0000);
    for (i = 0; i < 200 && n_fetch == 1; i++) @(posedge clk);
    check(n_fetch, 16'h0002);
    saw_nia = 1'b0;
    {tso, io_done, io_exec, cpu_next_addr} <= {2'b11, 4'h2, 16'h1FFF};
    @(posedge clk);
    io_done <= 1'b0;
    repeat (10) @(posedge clk);
    check(n_fetch, 16'h0002);
    check({d_hi, d_s, d_t, d_r}, 16'h1FFF);
    check({saw_nia, last_aux, last_wr_addr, last_wr_data}, {2'b11, 15'h0031, exp_byte(8'hFF)});
    {tso, io_exec} <= 5'h00;
    repeat (3) @(posedge clk);
    check(n_fetch, 16'h0003);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    wait_halt();
    check(ind, 16'h0015);
    // Main scan across the top of storage into the faulty byte at 0001
    run_op(console_seq_pkg::MODE_SCAN, 1'b0, 16'h1FFE);
    wait_halt();
    check(perr, 16'h0001);
    check({d_hi, d_s, d_t, d_r}, 16'h0001);
    check({nib_u, nib_l}, exp_byte(8'h01));
    check({ptr, ind}, 16'h0210);
    check(n_order, 16'h0000);
    // Aux scan: high switches must be ignored, FF steps straight to 00
    run_op(console_seq_pkg::MODE_SCAN, 1'b1, 16'h37FD);
    wait_halt();
    check({d_hi, d_s, d_t, d_r}, 16'h0001);
    check({last_aux, last_wr_addr}, 16'h8001);
    check(n_order, 16'h0000);
    run_op(console_seq_pkg::MODE_SCAN, 1'b1, 16'h0010);
    repeat (60) @(posedge clk);
    check(run_flag, 16'h0001);
    stop_key <= 1'b1;
    @(posedge clk);
    stop_key <= 1'b0;
    wait_halt();
    check(perr, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
